// [rtl/vscp_pkg.sv]
// package: constants and beat types for the video stream and control ports
// Notes on behaviour
// [R1] source zero-pads 10/12-bit samples at top
// [R2] output pads unused upper bits with zeros
// [R3] beat moves when ready, valid, enable, reset high
// [R4] only active pixels travel as beats
// [R5] source holds beat stable while valid waits
// [R6] source never withdraws an offered beat
// [R7] sink ready may come before/with/after valid
// [R8] sink should pre-assert ready for low latency
// [R9] user bit zero marks first pixel of frame
// [R10] frame marker may lead while valid low
// [R11] last marks final pixel of each line
// [R12] without control port use build-time settings
// [R13] control port steps on control clock edges
// [R14] control enable low freezes control port
// [R15] control reset overrides control enable
// [R16] control reset held low 32 slow cycles
// [R17] control reset also resets stream core
// [R18] control buses 32-bit, responses 2-bit
// [R19] core enable low freezes stream core
// [R20] stream reset overrides enable, 32 cycles
// [R21] stalled output beat stays stable until taken
package vscp_pkg;
  localparam int COMP_W        = 12;          // bits per colour component
  localparam int PIX_W         = 3 * COMP_W;  // packed pixel bits
  localparam int BUS_W         = 40;          // stream data bus width
  localparam int AXI_W         = 32;          // control address/data width
  localparam int RESP_W        = 2;           // control response width
  localparam int DIM_W         = 13;          // frame dimension width
  localparam int STR_W         = 3;           // smoothing strength width
  // control register offsets and fields
  localparam logic [AXI_W-1:0] OFS_ACTIVE_SIZE = 32'h0000_0020;
  localparam logic [AXI_W-1:0] OFS_STRENGTH    = 32'h0000_0100;
  localparam int COLS_LSB      = 0;           // pixels per line field
  localparam int ROWS_LSB      = 16;          // lines per frame field
  // build-time settings, also control reset values
  localparam logic [DIM_W-1:0] RST_COLS     = 13'h0780;
  localparam logic [DIM_W-1:0] RST_ROWS     = 13'h0438;
  localparam logic [STR_W-1:0] RST_STRENGTH = 3'h2;
  localparam logic [STR_W-1:0] MAX_STRENGTH = 3'h4;
  // response codes
  localparam logic [RESP_W-1:0] RESP_OKAY   = 2'h0;
  localparam logic [RESP_W-1:0] RESP_SLVERR = 2'h2;
  // one stream beat
  typedef struct packed {
    logic [BUS_W-1:0] data;  // pixel data
    logic             sof;   // start of frame, user bit zero
    logic             eol;   // end of line
  } vscp_beat_s;
  // active frame settings
  typedef struct packed {
    logic [DIM_W-1:0] cols;      // active pixels per line
    logic [DIM_W-1:0] rows;      // active lines per frame
    logic [STR_W-1:0] strength;  // smoothing strength
  } vscp_cfg_s;
endpackage

// [rtl/vscp_skid.sv]
// file: two-entry skid stage with registered ready and output
`timescale 1ns/1ps
module vscp_skid (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             sync_clr,
  input  wire logic             en,
  input  vscp_pkg::vscp_beat_s  in_beat,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output vscp_pkg::vscp_beat_s  out_beat,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  import vscp_pkg::*;

  vscp_beat_s spare_reg;   // beat caught while output stalled
  logic       spare_full;  // spare slot occupied
  logic       take_in;     // input beat transferred
  logic       take_out;    // output beat transferred

  // transfers only count with enable high and no clear
  assign take_in  = en && !sync_clr && in_valid && in_ready;   // [R3]
  assign take_out = en && !sync_clr && out_valid && out_ready; // [R3]

  // output stage, held while stalled
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_beat  <= '0;
    end else if (sync_clr) begin  // [R20]
      out_valid <= 1'b0;
      out_beat  <= '0;
    end else if (en) begin        // [R19]
      if (!out_valid || take_out) begin  // [R21]
        if (spare_full) begin
          out_valid <= 1'b1;
          out_beat  <= spare_reg;
        end else begin
          out_valid <= take_in;
          if (take_in) begin
            out_beat <= in_beat;
          end
        end
      end
    end
  end

  // spare slot absorbs the beat taken while ready was high
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      spare_full <= 1'b0;
      spare_reg  <= '0;
    end else if (sync_clr) begin
      spare_full <= 1'b0;
      spare_reg  <= '0;
    end else if (en) begin
      if (take_in && out_valid && !take_out && !spare_full) begin
        spare_full <= 1'b1;
        spare_reg  <= in_beat;
      end else if (spare_full && (!out_valid || take_out)) begin
        spare_full <= 1'b0;
      end
    end
  end

  // ready registered: high while spare slot will be free
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      in_ready <= 1'b0;
    end else if (sync_clr) begin
      in_ready <= 1'b0;
    end else if (en) begin
      if (take_in && out_valid && !take_out && !spare_full) begin
        in_ready <= 1'b0;
      end else if (spare_full && (!out_valid || take_out)) begin
        in_ready <= 1'b1;
      end else if (!spare_full) begin
        in_ready <= 1'b1;
      end
    end
  end
endmodule

// [rtl/vscp_top.sv]
// file: stream ports and control port of the video filtering core
`timescale 1ns/1ps
module vscp_top #(
  parameter bit HAS_CTRL = 1'b1
) (
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  // stream side clock enable and reset
  input  wire logic                          str_clk_en,
  input  wire logic                          str_rst_n,
  // input video stream
  input  wire logic [vscp_pkg::BUS_W-1:0]    s_axis_video_tdata,
  input  wire logic                          s_axis_video_tvalid,
  output logic                               s_axis_video_tready,
  input  wire logic                          s_axis_video_tuser,
  input  wire logic                          s_axis_video_tlast,
  // output video stream
  output logic [vscp_pkg::BUS_W-1:0]         m_axis_video_tdata,
  output logic                               m_axis_video_tvalid,
  input  wire logic                          m_axis_video_tready,
  output logic                               m_axis_video_tuser,
  output logic                               m_axis_video_tlast,
  // control port clocking, sampled on clk_sys
  input  wire logic                          ctl_clk,
  input  wire logic                          ctl_clk_en,
  input  wire logic                          ctl_rst_n,
  // control port channels
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [vscp_pkg::AXI_W-1:0]    s_axi_awaddr,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  input  wire logic [vscp_pkg::AXI_W-1:0]    s_axi_wdata,
  output logic [vscp_pkg::RESP_W-1:0]        s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  input  wire logic [vscp_pkg::AXI_W-1:0]    s_axi_araddr,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output logic [vscp_pkg::AXI_W-1:0]         s_axi_rdata,
  output logic [vscp_pkg::RESP_W-1:0]        s_axi_rresp,
  // active settings handed to the filter datapath
  output vscp_pkg::vscp_cfg_s                cfg_active
);
  import vscp_pkg::*;

  // ---------------- control clock edge ----------------
  logic ctl_clk_d1;   // control clock sampled
  logic ctl_clk_d2;   // previous sample
  logic ctl_edge;     // rising control clock edge
  logic ctl_step;     // control port advances this cycle
  logic ctl_clr;      // control reset taken this edge

  // edge of the control clock, seen on clk_sys
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctl_clk_d1 <= 1'b0;
      ctl_clk_d2 <= 1'b0;
    end else begin
      ctl_clk_d1 <= ctl_clk;
      ctl_clk_d2 <= ctl_clk_d1;
    end
  end

  assign ctl_edge = ctl_clk_d1 && !ctl_clk_d2;        // [R13]
  assign ctl_clr  = ctl_edge && !ctl_rst_n;           // [R15]
  assign ctl_step = ctl_edge && ctl_rst_n && ctl_clk_en; // [R14]

  // ---------------- control reset into core ----------------
  logic ctl_rst_hold;  // control reset seen, control side
  logic ctl_rst_s1;    // first synchroniser stage
  logic ctl_rst_s2;    // core side copy of control reset

  // control reset latched at control edges regardless of enable
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctl_rst_hold <= 1'b1;
    end else if (ctl_edge) begin
      ctl_rst_hold <= !ctl_rst_n;  // [R15]
    end
  end

  // two-stage resync toward the stream core
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctl_rst_s1 <= 1'b1;
      ctl_rst_s2 <= 1'b1;
    end else begin
      ctl_rst_s1 <= ctl_rst_hold && HAS_CTRL;  // [R17]
      ctl_rst_s2 <= ctl_rst_s1;
    end
  end

  logic core_clr;  // synchronous clear of stream core
  assign core_clr = !str_rst_n || ctl_rst_s2;  // [R20] [R17]

  // ---------------- control write channel ----------------
  vscp_cfg_s cfg_reg;     // processor side settings
  logic      wr_fire;     // address and data both offered
  logic      wr_hit_sz;   // write to size register
  logic      wr_hit_st;   // write to strength register

  assign wr_fire   = ctl_step && s_axi_awvalid && s_axi_wvalid &&
                     !s_axi_bvalid && !s_axi_awready;
  assign wr_hit_sz = (s_axi_awaddr == OFS_ACTIVE_SIZE);
  assign wr_hit_st = (s_axi_awaddr == OFS_STRENGTH);

  // accept pulses and write response
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else if (ctl_clr) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else if (ctl_step) begin  // [R14]
      s_axi_awready <= wr_fire;
      s_axi_wready  <= wr_fire;
      if (wr_fire) begin  // [R18]
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_hit_sz || wr_hit_st) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // settings registers, written only with the control port built
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_reg <= '{cols: RST_COLS, rows: RST_ROWS, strength: RST_STRENGTH};
    end else if (ctl_clr) begin
      cfg_reg <= '{cols: RST_COLS, rows: RST_ROWS, strength: RST_STRENGTH};
    end else if (ctl_step && wr_fire && HAS_CTRL) begin  // [R12]
      if (wr_hit_sz) begin
        cfg_reg.cols <= s_axi_wdata[COLS_LSB +: DIM_W];
        cfg_reg.rows <= s_axi_wdata[ROWS_LSB +: DIM_W];
      end
      if (wr_hit_st && s_axi_wdata[STR_W-1:0] <= MAX_STRENGTH) begin
        cfg_reg.strength <= s_axi_wdata[STR_W-1:0];
      end
    end
  end

  // ---------------- control read channel ----------------
  logic rd_fire;  // read address taken
  assign rd_fire = ctl_step && s_axi_arvalid && !s_axi_rvalid &&
                   !s_axi_arready;

  // read accept, data and response
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ctl_clr) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ctl_step) begin  // [R14]
      s_axi_arready <= rd_fire;
      if (rd_fire) begin  // [R18]
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= '0;
        s_axi_rresp  <= RESP_OKAY;
        if (s_axi_araddr == OFS_ACTIVE_SIZE) begin
          s_axi_rdata[COLS_LSB +: DIM_W] <= cfg_reg.cols;
          s_axi_rdata[ROWS_LSB +: DIM_W] <= cfg_reg.rows;
        end else if (s_axi_araddr == OFS_STRENGTH) begin
          s_axi_rdata[STR_W-1:0] <= cfg_reg.strength;
        end else begin
          s_axi_rresp <= RESP_SLVERR;  // unmapped
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------- active settings, commit at frame start ----------------
  logic in_take;  // input beat transferred this cycle
  assign in_take = str_clk_en && !core_clr && s_axis_video_tvalid &&
                   s_axis_video_tready;  // [R3]

  // settings switch on a frame boundary, or on a stream core clear, to avoid tearing
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_active <= '{cols: RST_COLS, rows: RST_ROWS, strength: RST_STRENGTH};
    end else if (core_clr) begin  // [R20]
      cfg_active <= cfg_reg;
    end else if (str_clk_en && in_take && s_axis_video_tuser) begin  // [R9]
      cfg_active <= HAS_CTRL ? cfg_reg :
        '{cols: RST_COLS, rows: RST_ROWS, strength: RST_STRENGTH}; // [R12]
    end
  end

  // ---------------- stream path ----------------
  vscp_beat_s in_beat;   // packed input beat
  vscp_beat_s out_beat;  // beat on output registers

  // repack: keep three components, zero the unused top bits
  always_comb begin
    in_beat      = '0;
    in_beat.data = {{(BUS_W-PIX_W){1'b0}},
                    s_axis_video_tdata[PIX_W-1:0]};  // [R2] [R1]
    in_beat.sof  = s_axis_video_tuser;  // [R9] [R10]
    in_beat.eol  = s_axis_video_tlast;  // [R11]
  end

  // stage with registered ready and held output
  vscp_skid u_skid (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .sync_clr  (core_clr),
    .en        (str_clk_en),
    .in_beat   (in_beat),
    .in_valid  (s_axis_video_tvalid),
    .in_ready  (s_axis_video_tready),
    .out_beat  (out_beat),
    .out_valid (m_axis_video_tvalid),
    .out_ready (m_axis_video_tready)
  );

  // markers travel with their pixel; only beats are forwarded
  assign m_axis_video_tdata = out_beat.data;  // [R4] [R21]
  assign m_axis_video_tuser = out_beat.sof;   // [R9]
  assign m_axis_video_tlast = out_beat.eol;   // [R11]
endmodule

// [dv/vscp_sva.sv]
// checker: timing rules seen at the top module ports
`timescale 1ns/1ps
module vscp_sva (
  input wire logic                       clk_sys,
  input wire logic                       rst,
  input wire logic                       str_clk_en,
  input wire logic                       str_rst_n,
  input wire logic                       s_axis_video_tvalid,
  input wire logic                       s_axis_video_tready,
  input wire logic [vscp_pkg::BUS_W-1:0] m_axis_video_tdata,
  input wire logic                       m_axis_video_tvalid,
  input wire logic                       m_axis_video_tready,
  input wire logic                       m_axis_video_tuser,
  input wire logic                       m_axis_video_tlast,
  input wire logic                       ctl_clk_en,
  input wire logic                       ctl_rst_n,
  input wire logic                       s_axi_bvalid,
  input wire logic                       s_axi_bready
);
  import vscp_pkg::*;
  wire ov = m_axis_video_tvalid;  // output beat offered
  wire ordy = m_axis_video_tready;  // sink ready
  wire in_hs = s_axis_video_tvalid && s_axis_video_tready;  // input beat
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // stalled beat keeps valid and contents
  property p_hold;
    str_rst_n && ov && !ordy |=> ov && $stable({m_axis_video_tdata,
      m_axis_video_tuser, m_axis_video_tlast});
  endproperty
  a_hold: assert property (p_hold) else $error("stalled beat moved");
  // unused upper data bits stay zero
  property p_pad;
    ov |-> m_axis_video_tdata[BUS_W-1:PIX_W] == '0;
  endproperty
  a_pad: assert property (p_pad) else $error("pad bits set");
  // output valid is high the cycle after an accepted input beat
  property p_in;
    in_hs && str_clk_en && str_rst_n |=> ov;
  endproperty
  a_in: assert property (p_in) else $error("beat not forwarded");
  // stopped enable freezes the stream side
  property p_frz;
    !str_clk_en && str_rst_n |=> $stable({ov, m_axis_video_tdata,
      s_axis_video_tready});
  endproperty
  a_frz: assert property (p_frz) else $error("stream moved while off");
  // stream reset clears valid and ready
  property p_clr;
    !str_rst_n |=> !ov && !s_axis_video_tready;
  endproperty
  a_clr: assert property (p_clr) else $error("stream not cleared");
  // write response waits for its ready
  property p_bv;
    s_axi_bvalid && !s_axi_bready && ctl_rst_n |=> s_axi_bvalid;
  endproperty
  a_bv: assert property (p_bv) else $error("response dropped");
  // stopped control enable holds the response
  property p_cen;
    (ctl_rst_n && !ctl_clk_en) [*3] |=> $stable(s_axi_bvalid);
  endproperty
  a_cen: assert property (p_cen) else $error("control moved while off");
  // control reset clears control and stream even when stopped
  property p_crs;
    !ctl_rst_n [*8] |-> !s_axi_bvalid && !s_axis_video_tready;
  endproperty
  a_crs: assert property (p_crs) else $error("control reset ignored");
  c_sof: cover property (ov && ordy && m_axis_video_tuser);
  c_stall: cover property (ov && !ordy);
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind vscp_top vscp_sva u_sva (.clk_sys(clk_sys), .rst(rst),
  .str_clk_en(str_clk_en), .str_rst_n(str_rst_n),
  .s_axis_video_tvalid(s_axis_video_tvalid),
  .s_axis_video_tready(s_axis_video_tready),
  .m_axis_video_tdata(m_axis_video_tdata),
  .m_axis_video_tvalid(m_axis_video_tvalid),
  .m_axis_video_tready(m_axis_video_tready),
  .m_axis_video_tuser(m_axis_video_tuser),
  .m_axis_video_tlast(m_axis_video_tlast), .ctl_clk_en(ctl_clk_en),
  .ctl_rst_n(ctl_rst_n), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready));

// [dv/vscp_partner.sv]
// partner: upstream video source and downstream sink
`timescale 1ns/1ps
module vscp_partner (
  input  wire logic                  clk_sys,
  input  wire logic                  str_clk_en,
  input  wire logic                  str_rst_n,
  input  wire logic                  go,
  input  wire logic                  gap,
  input  wire logic                  stall,
  input  int                         cols,
  input  int                         rows,
  input  wire logic                  tready,
  output logic [vscp_pkg::BUS_W-1:0] tdata = '0,
  output logic                       tvalid = 1'h0,
  output logic                       tuser = 1'h0,
  output logic                       tlast = 1'h0,
  output logic                       rdy = 1'h1
);
  import vscp_pkg::*;
  logic took = 1'h0;  // beat moved at last rising edge
  int   k    = 0;     // beats taken in this frame
  int   ph   = 0;     // sink stall phase
  // note a completed beat
  always @(posedge clk_sys) begin
    took <= tvalid && tready && str_clk_en && str_rst_n;
  end
  // both ends change just after the falling edge
  always @(negedge clk_sys) begin
    ph = ph + 1;
    rdy = !stall || ph % 3 == 0;
    k = go ? k + took : 0;
    // offered beat held until taken
    if (!tvalid || took) begin
      tvalid = go && k < cols * rows && !(gap && took);
      // idle lines wander, no stale value
      tdata = tvalid ? {4'h0, 12'(k), 12'(k ^ 5), 12'(k + 9)} : ~tdata;
      tuser = tvalid ? k == 0 : ~tuser;
      tlast = tvalid ? k % cols == cols - 1 : ~tlast;
    end
  end
endmodule

// [dv/vscp_top_tb.sv]
// testbench: stream and control port scenarios
`timescale 1ns/1ps
module vscp_top_tb;
  import vscp_pkg::*;
  logic              clk_sys = 1'h0, rst = 1'h1, en = 1'h1, srn = 1'h1;
  logic              cclk = 1'h0, cen = 1'h1, crn = 1'h1;
  logic              go = 1'h0, gap = 1'h0, stall = 1'h0;
  logic              awv = 1'h0, wv = 1'h0, bry = 1'h0;
  logic              arv = 1'h0, rry = 1'h0;
  logic [AXI_W-1:0]  awa = '0, wd = '0, ara = '0, rdat;
  logic [BUS_W-1:0]  s_data, m_data;
  logic              s_vld, s_rdy, s_sof, s_eol, m_vld, m_rdy, m_sof, m_eol;
  logic              awr, bv, wr, arr, rv;
  logic [RESP_W-1:0] bresp, rrsp;
  vscp_cfg_s         cfg;
  vscp_beat_s        q[$], exp_b;
  int                cols = 2, rows = 2, n_out, n_sof, n_eol, cyc = 0;
  int                num_errors = 0, total_checks = 0;
  vscp_top uut (.clk_sys(clk_sys), .rst(rst), .str_clk_en(en),
    .str_rst_n(srn), .s_axis_video_tdata(s_data),
    .s_axis_video_tvalid(s_vld), .s_axis_video_tready(s_rdy),
    .s_axis_video_tuser(s_sof), .s_axis_video_tlast(s_eol),
    .m_axis_video_tdata(m_data), .m_axis_video_tvalid(m_vld),
    .m_axis_video_tready(m_rdy), .m_axis_video_tuser(m_sof),
    .m_axis_video_tlast(m_eol), .ctl_clk(cclk), .ctl_clk_en(cen),
    .ctl_rst_n(crn), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_wdata(wd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .s_axi_rdata(rdat), .s_axi_rresp(rrsp), .cfg_active(cfg));
  vscp_partner far (.clk_sys(clk_sys), .str_clk_en(en), .str_rst_n(srn),
    .go(go), .gap(gap), .stall(stall), .cols(cols), .rows(rows),
    .tready(s_rdy), .tdata(s_data), .tvalid(s_vld), .tuser(s_sof),
    .tlast(s_eol), .rdy(m_rdy));
  // core clock and a slower control clock
  initial forever #25 clk_sys = ~clk_sys;
  initial forever begin
    repeat (2) @(negedge clk_sys);
    cclk = ~cclk;
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end
  // output beats must repeat accepted input beats in order
  always @(posedge clk_sys) begin
    if (rst || !srn || !crn) q.delete();
    else if (en) begin
      if (m_vld && m_rdy) begin
        exp_b = '1;
        if (q.size() > 0) exp_b = q.pop_front();
        check({m_data, m_sof, m_eol}, exp_b);
        n_out++;
        n_sof += m_sof;
        n_eol += m_eol;
      end
      if (s_vld && s_rdy) q.push_back({4'h0, s_data[PIX_W-1:0], s_sof, s_eol});
    end
  end
  task automatic wait_rdy;
    int i;
    for (i = 0; i < 50 && s_rdy !== 1'h1; i++) @(negedge clk_sys);
    check(s_rdy, 1'h1);
  endtask
  task automatic run_frame(input int c, input int r, input logic g,
                           input logic st);
    int i;
    cols = c;
    rows = r;
    gap = g;
    stall = st;
    n_out = 0;
    n_sof = 0;
    n_eol = 0;
    @(negedge clk_sys) go = 1'h1;
    for (i = 0; i < 2000 && n_out < c * r; i++) @(negedge clk_sys);
    go = 1'h0;
    check(n_out, c * r);
    check(n_sof, 1);
    check(n_eol, r);
  endtask
  // enable toggles every cycle for the first 14 cycles of a stalled frame
  task automatic en_toggle;
    fork
      run_frame(3, 2, 1'h0, 1'h1);
      repeat (14) @(negedge clk_sys) en = ~en;
    join
    en = 1'h1;
  endtask
  // stream reset wins over a stopped enable
  task automatic str_reset;
    @(negedge clk_sys);
    srn = 1'h0;
    en = 1'h0;
    repeat (32) @(negedge clk_sys);
    check(s_rdy, 1'h0);
    srn = 1'h1;
    en = 1'h1;
    wait_rdy();
    run_frame(2, 2, 1'h0, 1'h0);
  endtask
  task automatic ctl_write(input logic [31:0] a, input logic [31:0] d,
                           input logic [1:0] er, input logic hold);
    int i;
    logic [1:0] rsp;
    @(negedge clk_sys);
    awa = a;
    wd = d;
    awv = 1'h1;
    wv = 1'h1;
    if (hold) begin
      cen = 1'h0;
      repeat (24) @(negedge clk_sys);
      check(bv, 1'h0);
      cen = 1'h1;
    end
    for (i = 0; i < 200 && awr !== 1'h1; i++) @(negedge clk_sys);
    rsp = bresp;
    check(wr, 1'h1);
    check(bv, 1'h1);
    check(rsp, er);
    awv = 1'h0;
    wv = 1'h0;
    bry = 1'h1;
    for (i = 0; i < 200 && bv !== 1'h0; i++) @(negedge clk_sys);
    check(bv, 1'h0);
    bry = 1'h0;
  endtask
  // read back one setting register through the control port
  task automatic ctl_read(input logic [31:0] a, input logic [31:0] exp);
    int i;
    @(negedge clk_sys);
    ara = a;
    arv = 1'h1;
    for (i = 0; i < 200 && arr !== 1'h1; i++) @(negedge clk_sys);
    check(rv, 1'h1);
    check(rdat, exp);
    check(rrsp, RESP_OKAY);
    arv = 1'h0;
    rry = 1'h1;
    for (i = 0; i < 200 && rv !== 1'h0; i++) @(negedge clk_sys);
    check(rv, 1'h0);
    rry = 1'h0;
  endtask
  task automatic ctl_cfg;
    ctl_write(OFS_ACTIVE_SIZE, 32'h0003_0004, RESP_OKAY, 1'h1);
    ctl_write(OFS_STRENGTH, 32'h0000_0003, RESP_OKAY, 1'h0);
    ctl_write(32'h0000_0044, 32'h0000_0001, RESP_SLVERR, 1'h0);
    ctl_read(OFS_ACTIVE_SIZE, 32'h0003_0004);
    ctl_read(OFS_STRENGTH, 32'h0000_0003);
    run_frame(4, 3, 1'h0, 1'h0);
    check(cfg, {13'h0004, 13'h0003, 3'h3});
  endtask
  // control reset while its enable is low
  task automatic ctl_reset;
    @(negedge clk_sys);
    cen = 1'h0;
    crn = 1'h0;
    repeat (140) @(negedge clk_sys);
    check(cfg, {RST_COLS, RST_ROWS, RST_STRENGTH});
    check(s_rdy, 1'h0);
    crn = 1'h1;
    cen = 1'h1;
    wait_rdy();
  endtask
  initial begin
    repeat (16) @(negedge clk_sys);
    rst = 1'h0;
    wait_rdy();
    run_frame(4, 3, 1'h0, 1'h0);
    run_frame(5, 2, 1'h1, 1'h1);
    en_toggle();
    str_reset();
    ctl_cfg();
    ctl_reset();
    final_report();
  end
endmodule
